// *** ppc_pkg.sv ***
package ppc_pkg;
	// Geometry
	localparam int PPC_NUM_PORTS = 4;
	localparam int PPC_PORT_WIDTH = 8;
	localparam int PPC_NUM_PINS = PPC_NUM_PORTS * PPC_PORT_WIDTH;
	localparam int PPC_PORT_SEL_W = 2;
	localparam int PPC_BIT_SEL_W = 3;
	// Reset values and mode encodings
	localparam logic [7:0] PPC_LATCH_RESET = 8'hFF;
	localparam logic [7:0] PPC_MODE_RESET = 8'h00;
	localparam logic PPC_MODE_PUSH_PULL = 1'h1;
	localparam logic PPC_MODE_OPEN_DRAIN = 1'h0;
	// Access kinds
	typedef enum logic [2:0] {
		PPC_ACC_IDLE = 3'h1,
		PPC_ACC_BYTE = 3'h2,
		PPC_ACC_BIT = 3'h4
	} ppc_acc_t;
endpackage

// *** ppc_pin_drive.sv ***
`timescale 1ns/1ps
module ppc_pin_drive
	import ppc_pkg::*;
(
	// Configuration
	input wire logic xbar_en,
	input wire logic periph_assigned,
	input wire logic periph_input,
	input wire logic force_open_drain,
	input wire logic mode_push_pull,
	// Values
	input wire logic latch_value,
	input wire logic periph_value,
	// Pad drive
	output logic pad_out,
	output logic pad_oe_n
);
	logic value;
	logic drive;
	always_comb begin
		value = periph_assigned ? periph_value : latch_value;
		if (!xbar_en || periph_input) begin
			drive = 1'b0;
		end else if (mode_push_pull && !force_open_drain) begin
			drive = 1'b1;
		end else begin
			drive = !value;
		end
		pad_out = value;
		pad_oe_n = !drive;
	end
endmodule

// *** ppc_port_ctrl.sv ***
`timescale 1ns/1ps
// Behaviour
// - Assigned pins follow peripheral, not latch
// - Plain reads return sampled pin level
// - Read-modify-write reads return latch contents
// - Crossbar disabled forces all drivers off
// - Peripheral input pins never drive
// - Push-pull drives both levels
// - Open-drain drives low, releases high
// - Mode bit one push-pull, zero open-drain
// - Mode bits reset to open-drain
// - Serial bus and receive pins stay open-drain
// - Byte and bit access to port data
module ppc_port_ctrl
	import ppc_pkg::*;
#(
	parameter int NUM_PORTS = PPC_NUM_PORTS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Processor data access
	input wire logic data_wr,
	input wire logic data_rd,
	input wire logic bit_access,
	input wire logic rmw_read,
	input wire logic [PPC_PORT_SEL_W-1:0] port_sel,
	input wire logic [PPC_BIT_SEL_W-1:0] bit_sel,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	// Output mode registers
	input wire logic mode_wr,
	input wire logic [7:0] mode_wr_data,
	output logic [NUM_PORTS*8-1:0] port_output_mode_reg,
	// Crossbar
	input wire logic crossbar_global_enable,
	input wire logic [NUM_PORTS*8-1:0] periph_assigned,
	input wire logic [NUM_PORTS*8-1:0] periph_input,
	input wire logic [NUM_PORTS*8-1:0] force_open_drain,
	input wire logic [NUM_PORTS*8-1:0] periph_out,
	// Pads
	input wire logic [NUM_PORTS*8-1:0] pad_in,
	output logic [NUM_PORTS*8-1:0] pad_out,
	output logic [NUM_PORTS*8-1:0] pad_oe_n,
	// Status
	output logic [NUM_PORTS*8-1:0] port_latch
);
	localparam int NP = NUM_PORTS * 8;

	// ==========================================
	// State
	typedef struct packed {
		logic [NP-1:0] latch;
		logic [NP-1:0] mode;
		logic [NP-1:0] pin_sample;
		logic [7:0] rd_data;
	} ppc_state_t;

	ppc_state_t st;
	ppc_state_t next_st;
	ppc_acc_t acc;
	logic [NP-1:0] sel_mask;

	always_comb begin
		if (!data_wr) begin
			acc = PPC_ACC_IDLE;
		end else if (bit_access) begin
			acc = PPC_ACC_BIT;
		end else begin
			acc = PPC_ACC_BYTE;
		end
	end

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.pin_sample = pad_in;
		sel_mask = '0;
		case (acc)
			PPC_ACC_BYTE: begin
				sel_mask[port_sel*PPC_PORT_WIDTH +: PPC_PORT_WIDTH] = '1;
				next_st.latch = (st.latch & ~sel_mask) | ({NUM_PORTS{wr_data}} & sel_mask);
			end
			PPC_ACC_BIT: begin
				sel_mask[{port_sel, bit_sel}] = 1'b1;
				next_st.latch = (st.latch & ~sel_mask) | ({NP{wr_data[0]}} & sel_mask);
			end
			PPC_ACC_IDLE: begin
			end
			default: begin
			end
		endcase
		if (mode_wr) begin
			next_st.mode[port_sel*PPC_PORT_WIDTH +: PPC_PORT_WIDTH] = mode_wr_data;
		end
		if (data_rd) begin
			if (rmw_read) begin
				next_st.rd_data = st.latch[port_sel*PPC_PORT_WIDTH +: PPC_PORT_WIDTH];
			end else begin
				next_st.rd_data = st.pin_sample[port_sel*PPC_PORT_WIDTH +: PPC_PORT_WIDTH];
			end
			if (bit_access) begin
				next_st.rd_data = {7'h00, next_st.rd_data[bit_sel]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st.latch <= {NUM_PORTS{PPC_LATCH_RESET}};
			st.mode <= {NUM_PORTS{PPC_MODE_RESET}};
			st.pin_sample <= '0;
			st.rd_data <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign port_output_mode_reg = st.mode;
	assign port_latch = st.latch;

	// ==========================================
	// Pin drivers
	genvar gi;
	generate
		for (gi = 0; gi < NP; gi++) begin : g_pin
			ppc_pin_drive u_drv (
				.xbar_en(crossbar_global_enable),
				.periph_assigned(periph_assigned[gi]),
				.periph_input(periph_input[gi]),
				.force_open_drain(force_open_drain[gi]),
				.mode_push_pull(st.mode[gi]),
				.latch_value(st.latch[gi]),
				.periph_value(periph_out[gi]),
				.pad_out(pad_out[gi]),
				.pad_oe_n(pad_oe_n[gi])
			);
		end
	endgenerate

	// ==========================================
	// Checks
	property p_xbar_off;
		@(posedge clk) disable iff (rst) !crossbar_global_enable |-> (&pad_oe_n);
	endproperty
	a_xbar_off: assert property (p_xbar_off) else $error("driver on while crossbar off");

	property p_input_off;
		@(posedge clk) disable iff (rst) ((periph_input & ~pad_oe_n) == '0);
	endproperty
	a_input_off: assert property (p_input_off) else $error("peripheral input pin driven");

	property p_assigned_follow;
		@(posedge clk) disable iff (rst) ((periph_assigned & (pad_out ^ periph_out)) == '0);
	endproperty
	a_assigned_follow: assert property (p_assigned_follow) else $error("assigned pin not from peripheral");

	property p_od_release;
		@(posedge clk) disable iff (rst) ((~st.mode & pad_out & ~pad_oe_n) == '0);
	endproperty
	a_od_release: assert property (p_od_release) else $error("open-drain pin driving high");

	property p_forced_od;
		@(posedge clk) disable iff (rst) ((force_open_drain & pad_out & ~pad_oe_n) == '0);
	endproperty
	a_forced_od: assert property (p_forced_od) else $error("forced open-drain pin driving high");

	property p_pp_drive;
		@(posedge clk) disable iff (rst) crossbar_global_enable |->
			((st.mode & ~force_open_drain & ~periph_input & pad_oe_n) == '0);
	endproperty
	a_pp_drive: assert property (p_pp_drive) else $error("push-pull pin not driven");

	property p_mode_reset;
		@(posedge clk) rst |=> (port_output_mode_reg == '0);
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode bits not cleared by reset");

	property p_pin_read;
		@(posedge clk) disable iff (rst) (data_rd && !rmw_read && !bit_access) ##1 !$past(rst) |->
			rd_data == $past(st.pin_sample[port_sel*8 +: 8]);
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("plain read not pin level");

	property p_rmw_read;
		@(posedge clk) disable iff (rst) (data_rd && rmw_read && !bit_access) |=>
			rd_data == $past(port_latch[port_sel*8 +: 8]);
	endproperty
	a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch");

	property p_bit_write;
		@(posedge clk) disable iff (rst) (data_wr && bit_access) |=>
			port_latch[{$past(port_sel), $past(bit_sel)}] == $past(wr_data[0]);
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit write lost");

	property p_byte_write;
		@(posedge clk) disable iff (rst) (data_wr && !bit_access) |=>
			port_latch[$past(port_sel)*PPC_PORT_WIDTH +: PPC_PORT_WIDTH] == $past(wr_data);
	endproperty
	a_byte_write: assert property (p_byte_write) else $error("byte write lost");

	property p_mode_write;
		@(posedge clk) disable iff (rst) mode_wr |=>
			port_output_mode_reg[$past(port_sel)*PPC_PORT_WIDTH +: PPC_PORT_WIDTH] == $past(mode_wr_data);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode byte lost");

	property p_od_low;
		@(posedge clk) disable iff (rst) crossbar_global_enable |->
			(((~st.mode | force_open_drain) & ~periph_input & ~pad_out & pad_oe_n) == '0);
	endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain pin not pulled low");

	property p_bit_read;
		@(posedge clk) disable iff (rst) (data_rd && bit_access) |=> (rd_data[7:1] == 7'h00);
	endproperty
	a_bit_read: assert property (p_bit_read) else $error("bit read upper bits set");
endmodule

// *** ppc_pin_model.sv ***
`timescale 1ns/1ps
// ==========
// Pins and outside world
module ppc_pin_model
	import ppc_pkg::*;
(
	// From the block
	input wire logic [31:0] pad_out,
	input wire logic [31:0] pad_oe_n,
	// Outside drivers
	input wire logic [31:0] ext_drv,
	input wire logic [31:0] ext_en,
	// To the block
	output logic [31:0] pad_in
);
	// Released pins go to the outside driver or the pull-up
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			pad_in[i] = !pad_oe_n[i] ? pad_out[i] : (ext_en[i] ? ext_drv[i] : 1'h1);
		end
	end
endmodule

// *** ppc_port_ctrl_tb_top.sv ***
`timescale 1ns/1ps
// ==========
// Bench
module ppc_port_ctrl_tb_top;
	import ppc_pkg::*;
	logic clk = 0, rst = 1, dwr = 0, drd = 0, bac = 0, rmw = 0, mwr = 0, en = 0;
	logic [1:0] ps = 0;
	logic [2:0] bs = 0;
	logic [7:0] wd = 0, md8 = 0, rd;
	logic [31:0] md, lat, asg = 0, inp = 0, fod = 0, po = 0, xd = 0, xe = 0;
	logic [31:0] pin, pout, oen, mreg, plat, eo, ev;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	ppc_port_ctrl ppc_port_ctrl_i (.clk(clk), .rst(rst), .data_wr(dwr), .data_rd(drd), .bit_access(bac),
		.rmw_read(rmw), .port_sel(ps), .bit_sel(bs), .wr_data(wd), .rd_data(rd), .mode_wr(mwr),
		.mode_wr_data(md8), .port_output_mode_reg(mreg), .crossbar_global_enable(en), .periph_assigned(asg),
		.periph_input(inp), .force_open_drain(fod), .periph_out(po), .pad_in(pin), .pad_out(pout),
		.pad_oe_n(oen), .port_latch(plat));
	ppc_pin_model ppc_pin_model_i (.pad_out(pout), .pad_oe_n(oen), .ext_drv(xd), .ext_en(xe), .pad_in(pin));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic print_verdict();
		$display("Tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Byte or bit data write, or mode byte write
	task automatic acc(input logic m, input logic b, input logic [1:0] p, input logic [2:0] s, input logic [7:0] d);
		@(negedge clk);
		{mwr, dwr, bac, ps, bs, wd, md8} = {m, !m, b, p, s, d, d};
		@(negedge clk);
		{mwr, dwr} = 2'h0;
		for (int i = 0; i < 8; i++) begin
			if (m)
				md[{p, 3'(i)}] = d[i];
			else if (!b || 3'(i) == s)
				lat[{p, 3'(i)}] = b ? d[0] : d[i];
		end
	endtask
	task automatic step();
		repeat (2) @(negedge clk);
		ev = (asg & po) | (~asg & lat);
		eo = en ? (inp | (~(md & ~fod) & ev)) : 32'hFFFFFFFF;
		chk(oen, eo);
		chk(pout & ~eo, ev & ~eo);
	endtask
	task automatic rdc(input logic r, input logic b, input logic [1:0] p, input logic [2:0] s);
		logic [31:0] src;
		src = r ? lat : (~eo & ev) | (eo & (~xe | xd));
		@(negedge clk);
		{drd, rmw, bac, ps, bs} = {1'h1, r, b, p, s};
		@(negedge clk);
		{drd, rmw} = 2'h0;
		chk({24'h0, rd}, b ? {31'h0, src[{p, s}]} : {24'h0, src[{p, 3'h0} +: 8]});
	endtask
	initial begin
		void'($urandom(32'h36A4));
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 0;
		lat = 32'hFFFFFFFF;
		md = 32'h0;
		chk(mreg, 32'h0);
		chk(plat, lat);
		step();
		// Write port 0 latch while disabled, enable, then set port 0 push-pull
		acc(1'h0, 1'h0, 2'h0, 3'h0, 8'h0F);
		step();
		en = 1;
		step();
		acc(1'h1, 1'h0, 2'h0, 3'h0, 8'hFF);
		step();
		for (int k = 0; k < 300; k++) begin
			{asg, inp, fod, po, xd, xe} = {$urandom, $urandom & $urandom, $urandom & $urandom, $urandom, $urandom,
				$urandom};
			en = (k % 8) != 0;
			acc(1'($urandom), 1'($urandom), 2'($urandom), 3'($urandom), 8'($urandom));
			step();
			chk(mreg, md);
			chk(plat, lat);
			rdc(1'($urandom), 1'($urandom), 2'($urandom), 3'($urandom));
		end
		// Mid-run reset restores open-drain modes and released latches
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
		lat = 32'hFFFFFFFF;
		md = 32'h0;
		chk(mreg, md);
		chk(plat, lat);
		step();
		print_verdict();
	end
endmodule
